//--- sim/debug_programmer.sv
// Purpose: Behavioural debug-port programmer issuing byte accesses.
// Assumes: One access at a time, launched just after a clock edge.
// Notes: Released address and data lines show the inverse value.
`timescale 1ns/100ps
`default_nettype none
module debug_programmer (
  input wire logic i_clk,
  output logic o_wr_en,
  output logic o_wr_debug,
  output logic o_rd_en,
  output logic [15:0] o_addr,
  output logic [7:0] o_wdata
);
  initial begin
    o_wr_en = 1'b0;
    o_wr_debug = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 8'h00;
  end
  // Byte write; g high marks in-circuit programming.
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic g);
    @(posedge i_clk);
    o_wr_en <= 1'b1;
    o_wr_debug <= g;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge i_clk);
    o_rd_en <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_addr <= ~a;
  endtask : rd
endmodule : debug_programmer
`default_nettype wire

//--- sim/obcd_properties.sv
// Purpose: Concurrent checks on the option-byte decoder ports.
// Assumes: Writes are spaced by at least one idle cycle.
// Notes: Bound to the decoder after the module.
`timescale 1ns/100ps
`default_nettype none
module obcd_properties (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic i_wr_debug,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd_en,
  input wire logic o_rd_valid,
  input wire logic o_config_ready,
  input wire logic o_readout_protect,
  input wire logic o_indep_dog_auto_start,
  input wire logic o_indep_dog_halt_stop,
  input wire logic o_window_dog_auto_start,
  input wire logic o_window_dog_halt_reset,
  input wire logic [12:0] o_fast_osc_settle_cycles,
  input wire logic o_brownout_enable,
  input wire logic [2:0] o_brownout_threshold_sel
);
  localparam logic [12:0] ST [4] = '{13'h0001, 13'h0010, 13'h0200,
                                     13'h1000};
  wire wr_pr = i_wr_en && i_addr == 16'h4800;
  wire wr_dog = i_wr_en && i_addr == 16'h4808;
  wire wr_osc = i_wr_en && i_addr == 16'h4809;
  wire wr_bo = i_wr_en && i_addr == 16'h480A;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_read_answer: assert property (i_rd_en |=> o_rd_valid)
    else $error("read not answered");
  a_read_quiet: assert property (!i_rd_en |=> !o_rd_valid)
    else $error("read valid without request");
  a_protect_off: assert property (wr_pr && i_wr_debug &&
    i_wdata == 8'hAA |=> ##1 !o_readout_protect)
    else $error("protection not turned off");
  a_protect_lock: assert property (wr_pr && !i_wr_debug
    |=> ##1 $stable(o_readout_protect))
    else $error("application changed protection");
  a_dog_bits: assert property (
    wr_dog |=> ##1
    {o_window_dog_halt_reset, o_window_dog_auto_start,
     o_indep_dog_halt_stop, o_indep_dog_auto_start}
    == $past(i_wdata[3:0], 2))
    else $error("watchdog option bits wrong");
  a_fast_settle: assert property (wr_osc |=> ##1
    o_fast_osc_settle_cycles == ST[$past(i_wdata[1:0], 2)])
    else $error("fast settle count wrong");
  a_bo_enable: assert property (wr_bo |=> ##1
    o_brownout_enable == $past(i_wdata[0], 2))
    else $error("brownout enable wrong");
  a_bo_thresh: assert property (
    wr_bo && i_wdata[3:1] <= 3'h4
    |=> ##1 o_brownout_threshold_sel == $past(i_wdata[3:1], 2))
    else $error("brownout threshold wrong");
  a_ready_hold: assert property (o_config_ready |=> o_config_ready)
    else $error("ready dropped");
endmodule : obcd_properties
bind option_byte_config_decoder obcd_properties u_obcd_properties (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_wr_en(i_wr_en),
  .i_wr_debug(i_wr_debug), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_rd_en(i_rd_en), .o_rd_valid(o_rd_valid),
  .o_config_ready(o_config_ready), .o_readout_protect(o_readout_protect),
  .o_indep_dog_auto_start(o_indep_dog_auto_start),
  .o_indep_dog_halt_stop(o_indep_dog_halt_stop),
  .o_window_dog_auto_start(o_window_dog_auto_start),
  .o_window_dog_halt_reset(o_window_dog_halt_reset),
  .o_fast_osc_settle_cycles(o_fast_osc_settle_cycles),
  .o_brownout_enable(o_brownout_enable),
  .o_brownout_threshold_sel(o_brownout_threshold_sel));
`default_nettype wire

//--- sim/option_byte_config_decoder_test.sv
// Purpose: Self-checking bench for the option-byte decoder.
// Assumes: Load length shortened to 2 cycles.
// Notes: Accesses go through the debug programmer model.
`timescale 1ns/100ps
`default_nettype none
module option_byte_config_decoder_test;
  localparam logic [12:0] ST [4] = '{13'h0001, 13'h0010, 13'h0200,
                                     13'h1000};
  localparam logic [7:0] SZ [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hFF};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] vec = 8'h00;
  logic we, wd, re, rv, rdy, prot, aon, vo, rp, ia, ih, wa, wh, be, bl;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, pc;
  logic [12:0] fc, sc;
  logic [2:0] bt;
  int mismatches = 0;
  int checked = 0;
  option_byte_config_decoder #(.LOAD_LEN(2)) u_option_byte_config_decoder (
    .i_sys_clk(clk), .i_rst(rst), .i_wr_en(we), .i_wr_debug(wd),
    .i_addr(addr), .i_wdata(wdata), .i_rd_en(re),
    .i_reset_vector_opcode(vec), .o_rdata(rdata), .o_rd_valid(rv),
    .o_config_ready(rdy), .o_readout_protect(prot), .o_boot_area_on(aon),
    .o_boot_vectors_only(vo), .o_boot_read_protect(rp),
    .o_boot_page_count(pc), .o_indep_dog_auto_start(ia),
    .o_indep_dog_halt_stop(ih), .o_window_dog_auto_start(wa),
    .o_window_dog_halt_reset(wh), .o_fast_osc_settle_cycles(fc),
    .o_slow_osc_settle_cycles(sc), .o_brownout_enable(be),
    .o_brownout_threshold_sel(bt), .o_boot_to_loader(bl));
  debug_programmer u_debug_programmer (.i_clk(clk), .o_wr_en(we),
    .o_wr_debug(wd), .o_rd_en(re), .o_addr(addr), .o_wdata(wdata));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("Error t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic finish_test;
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // Write, then let the decoded outputs update.
  task automatic w(input logic [15:0] a, input logic [7:0] d,
                   input logic g);
    u_debug_programmer.wr(a, d, g);
    @(posedge clk);
    #1;
  endtask : w
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    u_debug_programmer.rd(a);
    #1;
    chk(rv, 1'b1);
    chk(rdata, e);
  endtask : rdc
  task automatic t_reset;
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, 4);
    if (rdy !== 1'b1) finish_test();
    chk(prot, 1'b0);
    chk(be, 1'b1);
    chk(fc, 13'h0001);
    rdc(16'h4800, 8'hAA);
    rdc(16'h480A, 8'h01);
  endtask : t_reset
  task automatic t_protect;
    w(16'h4800, 8'h55, 1'b1);
    chk(prot, 1'b1);
    w(16'h4800, 8'hAA, 1'b0);
    chk(prot, 1'b1);
    w(16'h4800, 8'hAA, 1'b1);
    chk(prot, 1'b0);
  endtask : t_protect
  task automatic t_boot_area;
    foreach (SZ[i]) begin
      w(16'h4802, SZ[i], 1'b1);
      chk({aon, vo, rp}, {SZ[i] != 0, SZ[i] == 1, SZ[i] == 2});
      chk(pc, SZ[i]);
    end
    w(16'h4802, 8'h05, 1'b0);
    chk(pc, 8'hFF);
  endtask : t_boot_area
  task automatic t_fields;
    for (int i = 0; i < 16; i++) begin
      w(16'h4808, {4'hF, i[3:0]}, 1'b0);
      chk({wh, wa, ih, ia}, i[3:0]);
      w(16'h4809, {4'h0, i[3:0]}, 1'b1);
      chk(fc, ST[i[1:0]]);
      chk(sc, ST[i[3:2]]);
      w(16'h480A, {4'h0, i[3:0]}, 1'b1);
      chk(be, i[0]);
      chk(bt, i[3:1] > 3'h4 ? 3'h4 : i[3:1]);
    end
    rdc(16'h4808, 8'h0F);
  endtask : t_fields
  task automatic t_boot_sel;
    w(16'h480B, 8'h12, 1'b0);
    chk(bl, 1'b1);
    @(posedge clk) vec <= 8'h82;
    repeat (2) @(posedge clk);
    #1;
    chk(bl, 1'b0);
    @(posedge clk) vec <= 8'h00;
    w(16'h480B, 8'h00, 1'b0);
    chk(bl, 1'b0);
    w(16'h480C, 8'h34, 1'b0);
    chk(bl, 1'b1);
  endtask : t_boot_sel
  task automatic t_reserved;
    w(16'h4807, 8'h5A, 1'b1);
    rdc(16'h4807, 8'h00);
    rdc(16'h4801, 8'h00);
  endtask : t_reserved
  // A reset in mid-run must bring back the default settings.
  task automatic t_rereset;
    @(posedge clk) rst <= 1'b1;
    @(posedge clk);
    #1;
    chk({rdy, prot, be, ia}, 4'h2);
    @(posedge clk) rst <= 1'b0;
    t_reset();
  endtask : t_rereset
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_protect();
    t_boot_area();
    t_fields();
    t_boot_sel();
    t_reserved();
    t_rereset();
    finish_test();
  end
endmodule : option_byte_config_decoder_test
`default_nettype wire

//--- src/boot_area_decode.sv
// Purpose: Decodes the boot-area size byte into page protection.
// Assumes: Pages numbered from 0.
// Notes: Pure combinational.
`timescale 1ns/100ps
`default_nettype none
`include "optcfg_cfg.svh"
module boot_area_decode (
  input wire logic [7:0] i_size,
  output logic o_area_on,
  output logic o_vectors_only,
  output logic o_read_protect,
  output logic [7:0] o_page_count
);
  assign o_area_on = (i_size != `UBC_NONE);
  assign o_vectors_only = (i_size == `UBC_VECTORS);
  assign o_read_protect = (i_size == `UBC_TWO_PAGES);
  // Pages 0 to size-1 are covered and write protected.
  assign o_page_count = i_size;
endmodule : boot_area_decode
`default_nettype wire

//--- src/optcfg_cfg.svh
// Purpose: Constants for the option-byte configuration decoder.
// Assumes: Byte-wide option store reached by data-memory address.
// Notes: Included by its bare name.
`ifndef OPTCFG_CFG_SVH
`define OPTCFG_CFG_SVH
// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define ADDR_READOUT_PROTECT 16'h4800
`define ADDR_BOOT_AREA_SIZE 16'h4802
`define ADDR_RESERVED_OPT 16'h4807
`define ADDR_WATCHDOG_OPT 16'h4808
`define ADDR_OSC_SETTLE 16'h4809
`define ADDR_BROWNOUT_OPT 16'h480A
`define ADDR_BOOT_SEL_LOW 16'h480B
`define ADDR_BOOT_SEL_HIGH 16'h480C
`define ADDR_RESET_VECTOR 16'h8000
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_READOUT_PROTECT 8'hAA
`define RST_BOOT_AREA_SIZE 8'h00
`define RST_WATCHDOG_OPT 8'h00
`define RST_OSC_SETTLE 8'h00
`define RST_BROWNOUT_OPT 8'h01
`define RST_BOOT_SEL 8'h00
// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define PROTECT_OFF_CODE 8'hAA
`define UBC_NONE 8'h00
`define UBC_VECTORS 8'h01
`define UBC_TWO_PAGES 8'h02
`define BIT_INDEP_AUTO 0
`define BIT_INDEP_HALT 1
`define BIT_WINDOW_AUTO 2
`define BIT_WINDOW_HALT 3
`define FAST_SEL_LSB 0
`define SLOW_SEL_LSB 2
`define BIT_BROWNOUT_EN 0
`define BROWNOUT_TH_LSB 1
`define BROWNOUT_TH_MAX 3'h4
`define WDOG_MASK 8'h0F
`define OSC_MASK 8'h0F
`define BROWNOUT_MASK 8'h0F
`define SETTLE_C0 13'h0001
`define SETTLE_C1 13'h0010
`define SETTLE_C2 13'h0200
`define SETTLE_C3 13'h1000
`define LOAD_CYCLES 4'h8
`endif

//--- src/optcfg_pkg.sv
// Purpose: Types for the option-byte configuration decoder.
// Assumes: Nothing.
// Notes: Load sequencer states are one-hot.
package optcfg_pkg;
  typedef enum logic [2:0] {
    ST_LOAD = 3'h1,
    ST_SETTLE = 3'h2,
    ST_RUN = 3'h4
  } load_state_t;
  typedef enum logic [1:0] {
    BOOT_RESET_VECTOR = 2'h0,
    BOOT_LOADER = 2'h1
  } boot_target_t;
endpackage : optcfg_pkg

//--- src/option_byte_config_decoder.sv
// Purpose: Option-byte store, write port and configuration decoder.
// Assumes: Byte writes by address from debug port or application.
// Notes: Outputs are registered and follow the store in every load state.
//
// Functional notes
// - Protect byte 0xAA means protection off.
// - Boot size 0,1,2 decode to none/vectors/two pages.
// - Sizes 3..255 cover pages 0..value-1.
// - Independent dog auto start bit starts it.
// - Independent dog halt bit stops it in halt.
// - Window dog auto start bit activates it.
// - Window dog halt bit resets on halt.
// - Fast oscillator settle code selects 1..4096.
// - Slow oscillator settle code selects 1..4096.
// - Brownout enable bit; default enabled.
// - Threshold field sits above enable bit.
// - Threshold codes 0..4 select levels 0..4.
// - Boot choice from select bytes and vector.
// - Debug port programming writes every option byte except the reserved byte at 0x4807.
// - Application cannot change protect or boot size.
`timescale 1ns/100ps
`default_nettype none
`include "optcfg_cfg.svh"
module option_byte_config_decoder #(
  parameter int LOAD_LEN = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic i_wr_debug,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd_en,
  input wire logic [7:0] i_reset_vector_opcode,
  output logic [7:0] o_rdata,
  output logic o_rd_valid,
  output logic o_config_ready,
  output logic o_readout_protect,
  output logic o_boot_area_on,
  output logic o_boot_vectors_only,
  output logic o_boot_read_protect,
  output logic [7:0] o_boot_page_count,
  output logic o_indep_dog_auto_start,
  output logic o_indep_dog_halt_stop,
  output logic o_window_dog_auto_start,
  output logic o_window_dog_halt_reset,
  output logic [12:0] o_fast_osc_settle_cycles,
  output logic [12:0] o_slow_osc_settle_cycles,
  output logic o_brownout_enable,
  output logic [2:0] o_brownout_threshold_sel,
  output logic o_boot_to_loader
);
  // ----------------------------------------------------------------
  // Option store
  // ----------------------------------------------------------------
  logic [7:0] protect_q;
  logic [7:0] boot_size_q;
  logic [7:0] wdog_q;
  logic [7:0] osc_q;
  logic [7:0] bor_q;
  logic [7:0] sel_lo_q;
  logic [7:0] sel_hi_q;
  wire hit_protect = (i_addr == `ADDR_READOUT_PROTECT);
  wire hit_size = (i_addr == `ADDR_BOOT_AREA_SIZE);
  wire hit_wdog = (i_addr == `ADDR_WATCHDOG_OPT);
  wire hit_osc = (i_addr == `ADDR_OSC_SETTLE);
  wire hit_bor = (i_addr == `ADDR_BROWNOUT_OPT);
  wire hit_lo = (i_addr == `ADDR_BOOT_SEL_LOW);
  wire hit_hi = (i_addr == `ADDR_BOOT_SEL_HIGH);
  // Protection and boot size accept only debug-port writes.
  wire wr_protect = i_wr_en & hit_protect & i_wr_debug;
  wire wr_size = i_wr_en & hit_size & i_wr_debug;
  wire wr_any = i_wr_en;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      protect_q <= `RST_READOUT_PROTECT;
    end else if (wr_protect) begin
      protect_q <= i_wdata;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      boot_size_q <= `RST_BOOT_AREA_SIZE;
    end else if (wr_size) begin
      boot_size_q <= i_wdata;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wdog_q <= `RST_WATCHDOG_OPT;
    end else if (wr_any & hit_wdog) begin
      wdog_q <= i_wdata & `WDOG_MASK;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      osc_q <= `RST_OSC_SETTLE;
    end else if (wr_any & hit_osc) begin
      osc_q <= i_wdata & `OSC_MASK;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      bor_q <= `RST_BROWNOUT_OPT;
    end else if (wr_any & hit_bor) begin
      bor_q <= i_wdata & `BROWNOUT_MASK;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_lo_q <= `RST_BOOT_SEL;
    end else if (wr_any & hit_lo) begin
      sel_lo_q <= i_wdata;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_hi_q <= `RST_BOOT_SEL;
    end else if (wr_any & hit_hi) begin
      sel_hi_q <= i_wdata;
    end
  end
  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    if (hit_protect) begin
      rd_mux = protect_q;
    end else if (hit_size) begin
      rd_mux = boot_size_q;
    end else if (hit_wdog) begin
      rd_mux = wdog_q;
    end else if (hit_osc) begin
      rd_mux = osc_q;
    end else if (hit_bor) begin
      rd_mux = bor_q;
    end else if (hit_lo) begin
      rd_mux = sel_lo_q;
    end else if (hit_hi) begin
      rd_mux = sel_hi_q;
    end else begin
      rd_mux = 8'h00;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rdata <= i_rd_en ? rd_mux : 8'h00;
      o_rd_valid <= i_rd_en;
    end
  end
  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  wire area_on;
  wire vectors_only;
  wire read_prot;
  wire [7:0] page_count;
  wire [12:0] fast_cycles;
  wire [12:0] slow_cycles;
  boot_area_decode u_boot_area (
    .i_size(boot_size_q),
    .o_area_on(area_on),
    .o_vectors_only(vectors_only),
    .o_read_protect(read_prot),
    .o_page_count(page_count)
  );
  settle_decode u_fast_settle (
    .i_code(osc_q[`FAST_SEL_LSB +: 2]),
    .o_cycles(fast_cycles)
  );
  settle_decode u_slow_settle (
    .i_code(osc_q[`SLOW_SEL_LSB +: 2]),
    .o_cycles(slow_cycles)
  );
  wire protect_on = (protect_q != `PROTECT_OFF_CODE);
  wire [2:0] th_raw = bor_q[`BROWNOUT_TH_LSB +: 3];
  // Codes above the top level clamp to the highest threshold.
  wire [2:0] th_sel = (th_raw > `BROWNOUT_TH_MAX) ?
                      `BROWNOUT_TH_MAX : th_raw;
  // Bootloader runs only if either select byte is nonzero and no program
  // has been written at the reset vector (erased opcode 0x00).
  wire boot_loader = ({sel_hi_q, sel_lo_q} != 16'h0000) &&
                     (i_reset_vector_opcode == 8'h00);
  // ----------------------------------------------------------------
  // Load sequencer
  // ----------------------------------------------------------------
  optcfg_pkg::load_state_t state_q;
  optcfg_pkg::load_state_t state_d;
  logic [3:0] load_cnt_q;
  wire load_done = (load_cnt_q == 4'(LOAD_LEN - 1));
  always_comb begin
    state_d = state_q;
    case (state_q)
      optcfg_pkg::ST_LOAD: begin
        state_d = optcfg_pkg::ST_SETTLE;
      end
      optcfg_pkg::ST_SETTLE: begin
        if (load_done) begin
          state_d = optcfg_pkg::ST_RUN;
        end
      end
      optcfg_pkg::ST_RUN: begin
        state_d = optcfg_pkg::ST_RUN;
      end
      default: begin
        state_d = optcfg_pkg::ST_LOAD;
      end
    endcase
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= optcfg_pkg::ST_LOAD;
      load_cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      if (state_q == optcfg_pkg::ST_SETTLE && !load_done) begin
        load_cnt_q <= load_cnt_q + 4'h1;
      end
    end
  end
  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_config_ready <= 1'b0;
    end else begin
      // Ready rises only after settings have stood a full cycle.
      o_config_ready <= (state_q == optcfg_pkg::ST_RUN);
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_readout_protect <= 1'b0;
    end else begin
      o_readout_protect <= protect_on;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_boot_area_on <= 1'b0;
    end else begin
      o_boot_area_on <= area_on;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_boot_vectors_only <= 1'b0;
    end else begin
      o_boot_vectors_only <= vectors_only;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_boot_read_protect <= 1'b0;
    end else begin
      o_boot_read_protect <= read_prot;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_boot_page_count <= 8'h00;
    end else begin
      o_boot_page_count <= page_count;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_indep_dog_auto_start <= 1'b0;
    end else begin
      o_indep_dog_auto_start <= wdog_q[`BIT_INDEP_AUTO];
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_indep_dog_halt_stop <= 1'b0;
    end else begin
      o_indep_dog_halt_stop <= wdog_q[`BIT_INDEP_HALT];
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_window_dog_auto_start <= 1'b0;
    end else begin
      o_window_dog_auto_start <= wdog_q[`BIT_WINDOW_AUTO];
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_window_dog_halt_reset <= 1'b0;
    end else begin
      o_window_dog_halt_reset <= wdog_q[`BIT_WINDOW_HALT];
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fast_osc_settle_cycles <= `SETTLE_C0;
    end else begin
      o_fast_osc_settle_cycles <= fast_cycles;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_slow_osc_settle_cycles <= `SETTLE_C0;
    end else begin
      o_slow_osc_settle_cycles <= slow_cycles;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_brownout_enable <= 1'b1;
    end else begin
      o_brownout_enable <= bor_q[`BIT_BROWNOUT_EN];
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_brownout_threshold_sel <= 3'h0;
    end else begin
      o_brownout_threshold_sel <= th_sel;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_boot_to_loader <= 1'b0;
    end else begin
      o_boot_to_loader <= boot_loader;
    end
  end
endmodule : option_byte_config_decoder
`default_nettype wire

//--- src/settle_decode.sv
// Purpose: Maps a two-bit settle code to an oscillator cycle count.
// Assumes: Codes 0 to 3.
// Notes: Pure combinational.
`timescale 1ns/100ps
`default_nettype none
`include "optcfg_cfg.svh"
module settle_decode (
  input wire logic [1:0] i_code,
  output logic [12:0] o_cycles
);
  assign o_cycles = (i_code == 2'h0) ? `SETTLE_C0 :
                    (i_code == 2'h1) ? `SETTLE_C1 :
                    (i_code == 2'h2) ? `SETTLE_C2 : `SETTLE_C3;
endmodule : settle_decode
`default_nettype wire
